/* sync_buck_gate_drive_control.sv */
// gate drive control: period timer, dead time, disables and fault flags
// Behaviour
// R1: separate high and low dead times, 4 ns steps
// R2: per-side bypass skips added dead time
// R3: global disable forces both gates low, node floats
// R4: per-side disable forces that gate low
// R5: period timer sets switching frequency, 100k-1.6M
// R6: input undervoltage flag follows comparator, hardware clears
// R7: input undervoltage compare only with its dac enabled
// R8: flags set regardless of interrupt enables
// R9: overcurrent checked while high side on, after blanking
// R10: overcurrent compare only with its dac enabled
// R11: firmware stops switching during input undervoltage
// R12: above 20V firmware uses output undervoltage termination
// R13: undervoltage termination holds gates low until cleared
// R14: gates never both high; forcing after dead time
module sync_buck_gate_drive_control (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic CE,
  input wire buck_drive_pkg::driver_cfg_t DRIVER_CFG,
  input wire buck_drive_pkg::timer_cfg_t TIMER_CFG,
  input wire buck_drive_pkg::prot_cfg_t PROT_CFG,
  input wire logic VIN_BELOW_THRESHOLD,
  input wire logic VOUT_BELOW_THRESHOLD,
  input wire logic OC_COMPARE_TRIP,
  input wire logic OUTPUT_UV_FLAG_CLEAR,
  input wire logic OC_FLAG_CLEAR,
  output logic HIGH_SIDE_GATE_OUT,
  output logic LOW_SIDE_GATE_OUT,
  output logic SWITCH_NODE_FLOAT,
  output buck_drive_pkg::fault_flags_t FAULT_FLAGS
);
  import buck_drive_pkg::*;

  // pin synchronisers
  logic [2:0] sync1_q, sync1_d;
  logic [2:0] sync2_q, sync2_d;
  logic vin_below, vout_below, oc_trip;

  always_comb begin
    sync1_d = {OC_COMPARE_TRIP, VOUT_BELOW_THRESHOLD, VIN_BELOW_THRESHOLD};
    sync2_d = sync1_q;
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (CE) begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign vin_below = sync2_q[0];
  assign vout_below = sync2_q[1];
  assign oc_trip = sync2_q[2];

  // period timer
  logic [PER_W-1:0] cnt_q, cnt_d;
  logic [PER_W-1:0] per_eff, on_eff;
  logic [1:0] demand;

  always_comb begin
    per_eff = TIMER_CFG.period_cycles;
    if (per_eff < PER_MIN_CYC) begin
      per_eff = PER_MIN_CYC; // see R5
    end else if (per_eff > PER_MAX_CYC) begin
      per_eff = PER_MAX_CYC; // see R5
    end
    on_eff = (TIMER_CFG.on_cycles > per_eff) ? per_eff : TIMER_CFG.on_cycles;
    if (cnt_q >= per_eff - CNT_ONE) begin
      cnt_d = CNT_ZERO; // see R5
    end else begin
      cnt_d = cnt_q + CNT_ONE;
    end
    demand[SIDE_HS] = (cnt_q < on_eff);
    demand[SIDE_LS] = !(cnt_q < on_eff);
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cnt_q <= CNT_ZERO;
    end else if (CE) begin
      cnt_q <= cnt_d;
    end
  end

  // dead-time stage, one lane per side
  logic on_q [2];
  logic on_d [2];
  logic [DT_W-1:0] dly_q [2];
  logic [DT_W-1:0] dly_d [2];
  logic [DT_W-1:0] dt_cyc [2];
  logic [1:0] bypass;
  logic [DT_W-1:0] dt_set [2];

  assign bypass = {DRIVER_CFG.low_side_delay_bypass, DRIVER_CFG.high_side_delay_bypass};
  assign dt_set[SIDE_HS] = DRIVER_CFG.dead_time_hs;
  assign dt_set[SIDE_LS] = DRIVER_CFG.dead_time_ls;

  for (genvar i = 0; i < 2; i++) begin : g_lane
    logic [DT_W+6:0] dt_ns;
    always_comb begin
      dt_ns = 11'(dt_set[i]) * 11'(DT_STEP_NS) + 11'(CLK_PERIOD_NS - 1);
      dt_cyc[i] = DT_W'(dt_ns / 11'(CLK_PERIOD_NS)); // see R1
      on_d[i] = on_q[i];
      dly_d[i] = dly_q[i];
      if (!demand[i]) begin
        on_d[i] = 1'b0;
        dly_d[i] = DLY_ZERO;
      end else if (!on_q[i]) begin
        if (bypass[i] || dly_q[i] >= dt_cyc[i]) begin
          on_d[i] = 1'b1; // see R2
        end else begin
          dly_d[i] = dly_q[i] + DLY_ONE; // see R1
        end
      end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
        on_q[i] <= 1'b0;
        dly_q[i] <= DLY_ZERO;
      end else if (CE) begin
        on_q[i] <= on_d[i];
        dly_q[i] <= dly_d[i];
      end
    end
  end

  // fault flags
  fault_flags_t flags_q, flags_d;
  logic [LEB_W-1:0] leb_q, leb_d, leb_len;
  logic leb_done;
  logic hs_q, ls_q, float_q;

  always_comb begin
    case (leb_sel_t'(PROT_CFG.blanking_select))
      SEL_LEB0: leb_len = LEB_CYC_0;
      SEL_LEB1: leb_len = LEB_CYC_1;
      SEL_LEB2: leb_len = LEB_CYC_2;
      SEL_LEB3: leb_len = LEB_CYC_3;
      default: leb_len = LEB_CYC_0;
    endcase
    leb_done = (leb_q >= leb_len);
    leb_d = leb_q;
    if (!hs_q) begin
      leb_d = LEB_ZERO; // see R9
    end else if (!leb_done) begin
      leb_d = leb_q + LEB_ONE; // see R9
    end
    flags_d = flags_q;
    // level flag, cleared by hardware when supply recovers
    flags_d.input_uv_flag = PROT_CFG.input_uv_dac_enable && vin_below; // see R6 see R7 see R8
    if (OUTPUT_UV_FLAG_CLEAR) begin
      flags_d.output_uv_flag = 1'b0;
    end
    if (PROT_CFG.output_uv_dac_enable && vout_below) begin
      flags_d.output_uv_flag = 1'b1; // see R8
    end
    if (OC_FLAG_CLEAR) begin
      flags_d.overcurrent_flag = 1'b0;
    end
    if (PROT_CFG.overcurrent_dac_enable && hs_q && leb_done && oc_trip) begin
      flags_d.overcurrent_flag = 1'b1; // see R9 see R10 see R8
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      flags_q <= '0;
      leb_q <= LEB_ZERO;
    end else if (CE) begin
      flags_q <= flags_d;
      leb_q <= leb_d;
    end
  end

  // output forcing after the dead-time stage
  logic force_all, hs_d, ls_d, float_d;

  always_comb begin
    force_all = DRIVER_CFG.whole_driver_disable ||
                (DRIVER_CFG.uv_terminate_enable && flags_q.output_uv_flag); // see R3 see R13
    hs_d = on_q[SIDE_HS] && !force_all && !DRIVER_CFG.high_side_disable; // see R4 see R14
    ls_d = on_q[SIDE_LS] && !on_q[SIDE_HS] && !force_all && !DRIVER_CFG.low_side_disable; // see R4 see R14
    float_d = DRIVER_CFG.whole_driver_disable; // see R3
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      float_q <= 1'b0;
    end else if (CE) begin
      hs_q <= hs_d;
      ls_q <= ls_d;
      float_q <= float_d;
    end
  end

  assign HIGH_SIDE_GATE_OUT = hs_q;
  assign LOW_SIDE_GATE_OUT = ls_q;
  assign SWITCH_NODE_FLOAT = float_q;
  assign FAULT_FLAGS = flags_q;

  // checks
  property p_no_overlap;
    @(posedge CLK_SYS) disable iff (!RST_B) !(hs_q && ls_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both gates high"); // see R14

  property p_global_off;
    @(posedge CLK_SYS) disable iff (!RST_B)
      CE && DRIVER_CFG.whole_driver_disable |=> !hs_q && !ls_q && float_q;
  endproperty
  a_global_off: assert property (p_global_off) else $error("global disable ignored"); // see R3

  property p_hs_off;
    @(posedge CLK_SYS) disable iff (!RST_B) CE && DRIVER_CFG.high_side_disable |=> !hs_q;
  endproperty
  a_hs_off: assert property (p_hs_off) else $error("high side disable ignored"); // see R4

  property p_ls_off;
    @(posedge CLK_SYS) disable iff (!RST_B) CE && DRIVER_CFG.low_side_disable |=> !ls_q;
  endproperty
  a_ls_off: assert property (p_ls_off) else $error("low side disable ignored"); // see R4

  property p_vin_flag;
    @(posedge CLK_SYS) disable iff (!RST_B)
      CE |=> flags_q.input_uv_flag == ($past(vin_below) && $past(PROT_CFG.input_uv_dac_enable));
  endproperty
  a_vin_flag: assert property (p_vin_flag) else $error("input uv flag wrong"); // see R6

  property p_vin_gate;
    @(posedge CLK_SYS) disable iff (!RST_B) CE && !PROT_CFG.input_uv_dac_enable |=> !flags_q.input_uv_flag;
  endproperty
  a_vin_gate: assert property (p_vin_gate) else $error("input uv flag without dac"); // see R7

  property p_oc_cause;
    @(posedge CLK_SYS) disable iff (!RST_B)
      $rose(flags_q.overcurrent_flag) |-> $past(hs_q) && $past(leb_done) && $past(PROT_CFG.overcurrent_dac_enable);
  endproperty
  a_oc_cause: assert property (p_oc_cause) else $error("overcurrent outside window"); // see R9

  property p_oc_dac;
    @(posedge CLK_SYS) disable iff (!RST_B)
      CE && !PROT_CFG.overcurrent_dac_enable && !flags_q.overcurrent_flag |=> !flags_q.overcurrent_flag;
  endproperty
  a_oc_dac: assert property (p_oc_dac) else $error("overcurrent without dac"); // see R10

  property p_uv_term;
    @(posedge CLK_SYS) disable iff (!RST_B)
      CE && DRIVER_CFG.uv_terminate_enable && flags_q.output_uv_flag |=> !hs_q && !ls_q;
  endproperty
  a_uv_term: assert property (p_uv_term) else $error("uv termination ignored"); // see R13

  property p_dead_time;
    @(posedge CLK_SYS) disable iff (!RST_B)
      $rose(on_q[SIDE_HS]) && !$past(bypass[SIDE_HS]) |-> $past(dly_q[SIDE_HS]) >= $past(dt_cyc[SIDE_HS]);
  endproperty
  a_dead_time: assert property (p_dead_time) else $error("dead time short"); // see R1

  property p_bypass;
    @(posedge CLK_SYS) disable iff (!RST_B)
      CE && bypass[SIDE_LS] && demand[SIDE_LS] && !on_q[SIDE_LS] |=> on_q[SIDE_LS];
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass added delay"); // see R2

  property p_period;
    @(posedge CLK_SYS) disable iff (!RST_B)
      CE |=> cnt_q < PER_MAX_CYC && (cnt_q == CNT_ZERO || cnt_q == $past(cnt_q) + CNT_ONE);
  endproperty
  a_period: assert property (p_period) else $error("period counter overrun"); // see R5

  // helper counters for the checks: cycles with both gates low, cycles with the high gate on
  logic [DT_W-1:0] gap_q, gap_d;
  logic [LEB_W-1:0] hs_run_q, hs_run_d;

  always_comb begin
    gap_d = (gap_q == '1) ? gap_q : gap_q + DLY_ONE;
    hs_run_d = (hs_run_q == LEB_CYC_3) ? hs_run_q : hs_run_q + LEB_ONE;
    if (hs_q || ls_q) begin
      gap_d = DLY_ZERO;
    end
    if (!hs_q) begin
      hs_run_d = LEB_ZERO;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      gap_q <= DLY_ZERO;
      hs_run_q <= LEB_ZERO;
    end else if (CE) begin
      gap_q <= gap_d;
      hs_run_q <= hs_run_d;
    end
  end

  property p_blank;
    @(posedge CLK_SYS) disable iff (!RST_B)
      $rose(flags_q.overcurrent_flag) |-> $past(hs_q) && $past(hs_run_q) >= $past(leb_len);
  endproperty
  a_blank: assert property (p_blank) else $error("overcurrent inside blanking"); // see R9

  property p_gap_hs;
    @(posedge CLK_SYS) disable iff (!RST_B)
      $rose(hs_q) && !$past(bypass[SIDE_HS], 2) |-> gap_q >= $past(dt_cyc[SIDE_HS], 2);
  endproperty
  a_gap_hs: assert property (p_gap_hs) else $error("high side dead time short"); // see R1 see R2

  property p_gap_ls;
    @(posedge CLK_SYS) disable iff (!RST_B)
      $rose(ls_q) && !$past(bypass[SIDE_LS], 2) |-> gap_q >= $past(dt_cyc[SIDE_LS], 2);
  endproperty
  a_gap_ls: assert property (p_gap_ls) else $error("low side dead time short"); // see R1 see R2

  property p_ce_freeze;
    @(posedge CLK_SYS) disable iff (!RST_B)
      !CE |=> $stable(hs_q) && $stable(ls_q) && $stable(float_q) && $stable(flags_q) && $stable(cnt_q);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with clock enable low");

  c_switching: cover property (@(posedge CLK_SYS) disable iff (!RST_B) $rose(hs_q) ##[1:300] $rose(ls_q));
  c_oc_trip: cover property (@(posedge CLK_SYS) disable iff (!RST_B) $rose(flags_q.overcurrent_flag));
  c_uv_term: cover property (@(posedge CLK_SYS) disable iff (!RST_B)
    DRIVER_CFG.uv_terminate_enable && $rose(flags_q.output_uv_flag));
  c_freeze: cover property (@(posedge CLK_SYS) disable iff (!RST_B) !CE ##1 !CE ##1 CE);
endmodule

/* buck_drive_pkg.sv */
// shared constants and carrier types for the buck gate drive control
package buck_drive_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_KHZ = 25000;
  localparam int DT_STEP_NS = 4;
  localparam int DT_W = 4;
  localparam int PER_W = 8;
  localparam int FSW_MIN_KHZ = 100;
  localparam int FSW_MAX_KHZ = 1600;
  localparam int PER_MAX_CYC_I = CLK_KHZ / FSW_MIN_KHZ;
  localparam int PER_MIN_CYC_I = (CLK_KHZ + FSW_MAX_KHZ - 1) / FSW_MAX_KHZ;
  localparam logic [PER_W-1:0] PER_MAX_CYC = PER_MAX_CYC_I[PER_W-1:0];
  localparam logic [PER_W-1:0] PER_MIN_CYC = PER_MIN_CYC_I[PER_W-1:0];
  localparam logic [PER_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [PER_W-1:0] CNT_ONE = 8'h01;
  localparam logic [DT_W-1:0] DLY_ZERO = 4'h0;
  localparam logic [DT_W-1:0] DLY_ONE = 4'h1;
  localparam int LEB_W = 4;
  localparam logic [LEB_W-1:0] LEB_CYC_0 = 4'h1;
  localparam logic [LEB_W-1:0] LEB_CYC_1 = 4'h2;
  localparam logic [LEB_W-1:0] LEB_CYC_2 = 4'h4;
  localparam logic [LEB_W-1:0] LEB_CYC_3 = 4'h8;
  localparam logic [LEB_W-1:0] LEB_ZERO = 4'h0;
  localparam logic [LEB_W-1:0] LEB_ONE = 4'h1;
  localparam int SIDE_HS = 0;
  localparam int SIDE_LS = 1;

  // dead-time and disable controls
  typedef struct packed {
    logic [DT_W-1:0] dead_time_hs;
    logic [DT_W-1:0] dead_time_ls;
    logic high_side_delay_bypass;
    logic low_side_delay_bypass;
    logic whole_driver_disable;
    logic high_side_disable;
    logic low_side_disable;
    logic uv_terminate_enable;
  } driver_cfg_t;

  // period timer setup
  typedef struct packed {
    logic [PER_W-1:0] period_cycles;
    logic [PER_W-1:0] on_cycles;
  } timer_cfg_t;

  // protection setup
  typedef struct packed {
    logic input_uv_dac_enable;
    logic output_uv_dac_enable;
    logic overcurrent_dac_enable;
    logic [1:0] blanking_select;
  } prot_cfg_t;

  typedef struct packed {
    logic input_uv_flag;
    logic output_uv_flag;
    logic overcurrent_flag;
  } fault_flags_t;

  typedef enum logic [1:0] {
    SEL_LEB0 = 2'h0,
    SEL_LEB1 = 2'h1,
    SEL_LEB2 = 2'h2,
    SEL_LEB3 = 2'h3
  } leb_sel_t;
endpackage

/* mosfet_pair_model.sv */
// behavioural external switch pair with a drain-source overcurrent comparator
module mosfet_pair_model (
  input wire logic clk,
  input wire logic hs_gate,
  input wire logic ls_gate,
  input wire logic node_float,
  input wire logic oc_cmd,
  output logic oc_trip,
  output int overlap_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  initial overlap_cnt = 0;
  // drop is only seen while the high side conducts
  assign oc_trip = hs_gate & oc_cmd & ~node_float;
  // shoot-through would short the supply
  always @(posedge clk) begin
    if (hs_gate === 1'b1 && ls_gate === 1'b1) overlap_cnt <= overlap_cnt + 1;
  end
endmodule

/* testbench.sv */
// self-checking bench for the buck gate drive control
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import buck_drive_pkg::*;
  logic clk_sys = 1'b0;
  logic ce = 1'b1;
  logic rst_b = 1'b0;
  driver_cfg_t dc = '0;
  timer_cfg_t tc = '{8'h10, 8'h08};
  prot_cfg_t pc = '0;
  logic vin_lo = 1'b0, vout_lo = 1'b0, oc_cmd = 1'b0, uv_clr = 1'b0, oc_clr = 1'b0;
  logic hs, ls, flt, trip;
  fault_flags_t ff;
  int error_cnt = 0, check_count = 0, cyc = 0, ovl, h, l;
  always #20 clk_sys = ~clk_sys;
  sync_buck_gate_drive_control sync_buck_gate_drive_control_inst (.CLK_SYS(clk_sys), .RST_B(rst_b), .CE(ce),
    .DRIVER_CFG(dc), .TIMER_CFG(tc), .PROT_CFG(pc), .VIN_BELOW_THRESHOLD(vin_lo), .VOUT_BELOW_THRESHOLD(vout_lo),
    .OC_COMPARE_TRIP(trip), .OUTPUT_UV_FLAG_CLEAR(uv_clr), .OC_FLAG_CLEAR(oc_clr), .HIGH_SIDE_GATE_OUT(hs),
    .LOW_SIDE_GATE_OUT(ls), .SWITCH_NODE_FLOAT(flt), .FAULT_FLAGS(ff));
  mosfet_pair_model mosfet_pair_model_inst (.clk(clk_sys), .hs_gate(hs), .ls_gate(ls), .node_float(flt),
    .oc_cmd(oc_cmd), .oc_trip(trip), .overlap_cnt(ovl));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // settle, then count gate-high cycles over a whole number of periods
  task automatic gates(input int n, input int eh, input int el);
    wait_n(40);
    h = 0;
    l = 0;
    repeat (n) begin
      @(negedge clk_sys);
      if (hs === 1'b1) h++;
      if (ls === 1'b1) l++;
    end
    chk(h[15:0], eh[15:0]);
    chk(l[15:0], el[15:0]);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    wait_n(6);
    rst_b = 1'b1;
    gates(64, 32, 32);
    dc.dead_time_hs = 4'hf;
    gates(64, 24, 32);
    dc.dead_time_ls = 4'ha;
    gates(64, 24, 28);
    dc.high_side_delay_bypass = 1'b1;
    dc.low_side_delay_bypass = 1'b1;
    gates(64, 32, 32);
    $display("test dead time done");
    dc.whole_driver_disable = 1'b1;
    gates(64, 0, 0);
    chk(flt, 1'b1);
    dc.whole_driver_disable = 1'b0;
    gates(64, 32, 32);
    chk(flt, 1'b0);
    dc.high_side_disable = 1'b1;
    gates(64, 0, 32);
    dc.high_side_disable = 1'b0;
    dc.low_side_disable = 1'b1;
    gates(64, 32, 0);
    dc.low_side_disable = 1'b0;
    $display("test disables done");
    ce = 1'b0;
    h = hs;
    l = ls;
    dc.whole_driver_disable = 1'b1;
    wait_n(10);
    chk(hs, h[15:0]);
    chk(ls, l[15:0]);
    chk(flt, 1'b0);
    ce = 1'b1;
    wait_n(2);
    chk({hs, ls, flt}, 3'h1);
    dc.whole_driver_disable = 1'b0;
    $display("test clock enable done");
    tc = '{8'h14, 8'h05};
    gates(80, 20, 60);
    tc = '{8'h0a, 8'h08};
    gates(64, 32, 32);
    tc = '{8'hff, 8'h7d};
    gates(250, 125, 125);
    tc = '{8'h10, 8'h08};
    $display("test period done");
    vin_lo = 1'b1;
    wait_n(6);
    chk(ff.input_uv_flag, 1'b0);
    pc.input_uv_dac_enable = 1'b1;
    wait_n(4);
    chk(ff.input_uv_flag, 1'b1);
    dc.high_side_disable = ff.input_uv_flag;
    dc.low_side_disable = ff.input_uv_flag;
    gates(64, 0, 0);
    dc.high_side_disable = 1'b0;
    dc.low_side_disable = 1'b0;
    vin_lo = 1'b0;
    wait_n(4);
    chk(ff.input_uv_flag, 1'b0);
    dc.uv_terminate_enable = 1'b1;
    pc.output_uv_dac_enable = 1'b1;
    vout_lo = 1'b1;
    wait_n(4);
    vout_lo = 1'b0;
    gates(64, 0, 0);
    chk(ff.output_uv_flag, 1'b1);
    uv_clr = 1'b1;
    wait_n(1);
    uv_clr = 1'b0;
    gates(64, 32, 32);
    chk(ff.output_uv_flag, 1'b0);
    $display("test undervoltage done");
    vout_lo = 1'b1;
    wait_n(4);
    vout_lo = 1'b0;
    wait_n(4);
    chk(ff.output_uv_flag, 1'b1);
    rst_b = 1'b0;
    wait_n(6);
    chk({hs, ls, flt, ff}, 6'h00);
    rst_b = 1'b1;
    gates(64, 32, 32);
    chk(ff.output_uv_flag, 1'b0);
    $display("test reset done");
    tc = '{8'h20, 8'h14};
    oc_cmd = 1'b1;
    wait_n(64);
    chk(ff.overcurrent_flag, 1'b0);
    pc.overcurrent_dac_enable = 1'b1;
    for (int s = 0; s < 4; s++) begin
      pc.blanking_select = s[1:0];
      oc_cmd = 1'b1;
      wait_n(64);
      chk(ff.overcurrent_flag, 1'b1);
      oc_cmd = 1'b0;
      wait_n(4);
      oc_clr = 1'b1;
      wait_n(1);
      oc_clr = 1'b0;
      wait_n(2);
      chk(ff.overcurrent_flag, 1'b0);
    end
    dc.high_side_disable = 1'b1;
    oc_cmd = 1'b1;
    wait_n(64);
    chk(ff.overcurrent_flag, 1'b0);
    dc.high_side_disable = 1'b0;
    tc = '{8'h10, 8'h04};
    wait_n(64);
    chk(ff.overcurrent_flag, 1'b0);
    pc.blanking_select = 2'h1;
    wait_n(64);
    chk(ff.overcurrent_flag, 1'b1);
    oc_cmd = 1'b0;
    wait_n(4);
    oc_clr = 1'b1;
    wait_n(1);
    oc_clr = 1'b0;
    pc.blanking_select = 2'h2;
    oc_cmd = 1'b1;
    wait_n(64);
    chk(ff.overcurrent_flag, 1'b0);
    chk(ovl[15:0], 16'h0000);
    $display("test overcurrent done");
    wrap_up();
  end
endmodule
